// ---- tb/lds_diag_checker.sv ----
`timescale 1ns/1ps
module lds_diag_checker import lds_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Results and serial pins
    input wire logic results_valid,
    input wire logic [7:0] group_b_open_check_second,
    input wire logic ser_latch,
    input wire logic ser_out,
    input wire logic irq,
    // Register bus
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic top_bit;
    // Bit that must lead the frame; replaced on every result load
    always_ff @(posedge clk) begin
        if (rst) begin
            top_bit <= 1'b0;
        end else if (results_valid) begin
            top_bit <= group_b_open_check_second[7];
        end
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence latch_seen;
        $rose(ser_latch) && !results_valid;
    endsequence
    reset_quiet_a: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active after reset");
    frame_head_a: assert property (latch_seen |-> ##[1:3] ser_out == top_bit)
        else $error("frame does not start with top bit");
    write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    decode_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == '0)
        else $error("unmapped read returned data");
endmodule
bind lds_diag lds_diag_checker u_chk (.*);

// ---- tb/lds_diag_tb_top.sv ----
`timescale 1ns/1ps
module lds_diag_tb_top import lds_pkg::*;;
    typedef struct packed {
        logic [87:0] g;
        logic [3:0] f;
        logic [1:0] n;
    } lds_row_t;
    localparam int POS [11] = '{POS_B_OPEN2, POS_R_OPEN2, POS_B_OPEN1, POS_R_OPEN1,
        POS_B_NSHORT, POS_NU_NSHORT, POS_R_NSHORT, POS_B_SHORT2, POS_R_SHORT2,
        POS_B_SHORT1, POS_R_SHORT1};
    localparam lds_row_t ROWS [4] = '{'{88'h0102040810204080a55ac3, 4'ha, 2'b10},
        '{88'h80402010080402015aa53c, 4'h5, 2'b01}, '{88'h0, 4'h0, 2'b00},
        '{{88{1'b1}}, 4'hf, 2'b11}};
    logic clk, rst, rv, nsd, nsf, osd, osf, ser_clk, ser_latch, ser_in, ser_out, irq;
    logic [87:0] gv, lg;
    logic [3:0] fv, lf, s_axi_wstrb;
    logic [1:0] nv, r, s_axi_bresp, s_axi_rresp;
    logic [2:0] ns_code, os_code;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int error_cnt = 0;
    int tests_run = 0;
    lds_diag u_dut (.*, .results_valid(rv),
        .group_b_open_check_second(gv[87:80]), .group_r_open_check_second(gv[79:72]),
        .group_b_open_check_first(gv[71:64]), .group_r_open_check_first(gv[63:56]),
        .group_b_neighbour_short(gv[55:48]), .unused_pin_neighbour_short(gv[47:40]),
        .group_r_neighbour_short(gv[39:32]), .group_b_short_check_second(gv[31:24]),
        .group_r_short_check_second(gv[23:16]), .group_b_short_check_first(gv[15:8]),
        .group_r_short_check_first(gv[7:0]), .thermal_error_flag(fv[3]),
        .thermal_warning_flag(fv[2]), .ref_resistor_short_fault(fv[1]),
        .ref_resistor_open_fault(fv[0]), .neighbour_selftest_done(nsd),
        .neighbour_selftest_failed(nsf), .open_short_selftest_done(osd),
        .open_short_selftest_failed(osf), .negate_bit_one(nv[1]), .negate_bit_zero(nv[0]));
    lds_host_model u_host (.*);
    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs about 3000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [FRAME_BITS-1:0] e, s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // Address and data are offered together and released one by one
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] b);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        b = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk); // Let an edge pass so a next call never re-drives bready at once
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] b);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        b = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk); // Let an edge pass so a next call never re-drives rready at once
    endtask
    function automatic logic [FRAME_BITS-1:0] expw();
        logic [FRAME_BITS-1:0] w;
        w = '0;
        for (int k = 0; k < 11; k++) w[POS[k]+:8] = lg[87-8*k-:8];
        {w[POS_TEF], w[POS_PTW], w[POS_ISF], w[POS_IOF]} = lf;
        {w[POS_NEGATE_BIT_ONE], w[POS_NEGATE_BIT_ZERO]} = nv;
        w[POS_NS_CODE+:3] = ns_code;
        w[POS_OS_CODE+:3] = os_code;
        return w;
    endfunction
    // Read back all nine words of the status word
    task automatic chk_all();
        for (int i = 0; i < DIAG_WORDS; i++) begin
            axr(8'(4 * i), d, r);
            chk("word", 288'(expw() >> (32 * i)) & 288'hffffffff, d);
            chk("rresp", RESP_OKAY, r);
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, rv, nsd, nsf, osd, osf, gv, fv, nv} = {1'b1, 98'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
        {lg, lf, ns_code, os_code} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk_all();
        axr(OFF_IRQ_MASK, d, r);
        chk("mask", MASK_RESET, d);
        // Results are replaced, never merged, on each load
        foreach (ROWS[k]) begin
            {gv, fv, nv} <= ROWS[k];
            rv <= 1'b1;
            @(posedge clk);
            rv <= 1'b0;
            {lg, lf} = {ROWS[k].g, ROWS[k].f};
            repeat (2) @(posedge clk);
            chk_all();
        end
        // Every pass and fail mix of both self-tests
        for (int k = 0; k < 4; k++) begin
            {nsf, osf, nsd, osd} <= {2'(k), 2'b11};
            @(posedge clk);
            {nsd, osd} <= 2'b00;
            ns_code = k[1] ? SELFTEST_FAIL : SELFTEST_PASS;
            os_code = k[0] ? SELFTEST_FAIL : SELFTEST_PASS;
            repeat (2) @(posedge clk);
            chk_all();
        end
        // Read-only word and unmapped place
        axw(OFF_DIAG0, 32'hffffffff, r);
        chk("bresp", RESP_SLVERR, r);
        axw(8'h2c, 32'h0, r);
        chk("bresp", RESP_DECERR, r);
        axr(8'h2c, d, r);
        chk("rresp", RESP_DECERR, r);
        chk("rdata", 32'h0, d);
        chk_all();
        // Frame out, latch event raises irq only while unmasked
        axw(OFF_IRQ_MASK, 32'h80, r);
        axr(OFF_IRQ_STATUS, d, r);
        chk("status", 32'h7f, d);
        for (int k = 0; k < 2; k++) begin
            u_host.xfer(~expw());
            chk("frame", expw(), u_host.rx);
            repeat (3) @(posedge clk);
            chk("irq", k == 0, irq);
            axr(OFF_IRQ_STATUS, d, r);
            chk("status", 32'h80, d);
            repeat (3) @(posedge clk);
            chk("irq", 1'b0, irq);
            axw(OFF_IRQ_MASK, 32'h0, r);
        end
        // Reset in mid-run clears loaded results
        rst <= 1'b1;
        nv <= 2'b00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        {lg, lf, ns_code, os_code} = '0;
        chk_all();
        end_of_test();
    end
endmodule

// ---- tb/lds_host_model.sv ----
`timescale 1ns/1ps
module lds_host_model import lds_pkg::*; (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic ser_clk,
    output logic ser_latch,
    output logic ser_in,
    input wire logic ser_out
);
    logic [FRAME_BITS-1:0] rx;
    // ------------------------------------------------------------
    // Frame exchange
    // ------------------------------------------------------------
    // Serial clock parks low between frames
    initial begin
        ser_clk = 1'b0;
        ser_latch = 1'b0;
        ser_in = 1'b1;
    end
    // Latch, then one whole frame MSB first; each level held two cycles
    task automatic xfer(input logic [FRAME_BITS-1:0] tx);
        @(posedge clk);
        ser_latch <= 1'b1;
        repeat (2) @(posedge clk);
        ser_latch <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            rx[i] = ser_out;
            ser_in <= tx[i];
            ser_clk <= 1'b1;
            repeat (2) @(posedge clk);
            ser_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        ser_in <= ~tx[0]; // Idle data must not echo the last bit
    endtask
endmodule

// ---- verilog/lds_diag.sv ----
`timescale 1ns/1ps
module lds_diag import lds_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Detection results, taken when results_valid is high
    input wire logic results_valid,
    input wire logic [7:0] group_b_open_check_second,
    input wire logic [7:0] group_r_open_check_second,
    input wire logic [7:0] group_b_open_check_first,
    input wire logic [7:0] group_r_open_check_first,
    input wire logic [7:0] group_b_neighbour_short,
    input wire logic [7:0] unused_pin_neighbour_short,
    input wire logic [7:0] group_r_neighbour_short,
    input wire logic [7:0] group_b_short_check_second,
    input wire logic [7:0] group_r_short_check_second,
    input wire logic [7:0] group_b_short_check_first,
    input wire logic [7:0] group_r_short_check_first,
    input wire logic thermal_error_flag,
    input wire logic thermal_warning_flag,
    input wire logic ref_resistor_short_fault,
    input wire logic ref_resistor_open_fault,
    // Self-test outcomes, taken on their done strobes
    input wire logic neighbour_selftest_done,
    input wire logic neighbour_selftest_failed,
    input wire logic open_short_selftest_done,
    input wire logic open_short_selftest_failed,
    // Negate bits as currently held
    input wire logic negate_bit_one,
    input wire logic negate_bit_zero,
    // Serial frame pins
    input wire logic ser_clk,
    input wire logic ser_latch,
    input wire logic ser_in,
    output logic ser_out,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [FRAME_BITS-1:0] word;
        logic [EVT_W-1:0] mask;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic aw_rdy;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic sclk_q;
        logic latch_q;
        logic irq;
    } lds_core_t;

    lds_core_t s;
    lds_core_t next_s;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_clr;
    logic [EVT_W-1:0] status_q;
    logic [FRAME_BITS-1:0] rise;
    logic latch_edge;
    logic [2:0] ns_new;
    logic [2:0] os_new;

    // Shifter keeps its own copy, so a bus read never stalls a frame
    lds_frame_if fr ();

    // ------------------------------------------------------------
    // Serial frame path
    // ------------------------------------------------------------
    // Pins are synchronous to clk, so plain edge detection is safe
    assign latch_edge = ser_latch & ~s.latch_q;
    assign fr.load = latch_edge;
    assign fr.shift = ser_clk & ~s.sclk_q;
    assign fr.sdi = ser_in;
    assign fr.word = s.word;

    lds_shifter u_shift (
        .clk(clk),
        .rst(rst),
        .fr(fr.shf)
    );

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    lds_sticky #(.W(EVT_W)) u_sticky (
        .clk(clk),
        .rst(rst),
        .set(evt),
        .clr(evt_clr),
        .q(status_q)
    );

    // Fault bits that turn on in this update
    assign rise = next_s.word & ~s.word;
    assign ns_new = next_s.word[POS_NS_CODE +: 3];
    assign os_new = next_s.word[POS_OS_CODE +: 3];

    // Event per category; only new faults raise them, except the latch event, raised by each latch edge
    always_comb begin
        evt = '0;
        evt[EVT_OPEN] = |{rise[POS_B_OPEN2 +: GRP_BITS], rise[POS_R_OPEN2 +: GRP_BITS],
            rise[POS_B_OPEN1 +: GRP_BITS], rise[POS_R_OPEN1 +: GRP_BITS]};
        evt[EVT_SHORT] = |{rise[POS_B_SHORT2 +: GRP_BITS], rise[POS_R_SHORT2 +: GRP_BITS],
            rise[POS_B_SHORT1 +: GRP_BITS], rise[POS_R_SHORT1 +: GRP_BITS]};
        evt[EVT_NSHORT] = |{rise[POS_B_NSHORT +: GRP_BITS], rise[POS_NU_NSHORT +: GRP_BITS],
            rise[POS_R_NSHORT +: GRP_BITS]};
        evt[EVT_TEF] = rise[POS_TEF];
        evt[EVT_PTW] = rise[POS_PTW];
        evt[EVT_REF] = rise[POS_ISF] | rise[POS_IOF];
        evt[EVT_SELFTEST] = (ns_new == SELFTEST_FAIL
            && s.word[POS_NS_CODE +: 3] != SELFTEST_FAIL)
            || (os_new == SELFTEST_FAIL
            && s.word[POS_OS_CODE +: 3] != SELFTEST_FAIL);
        evt[EVT_LATCH] = latch_edge;
    end

    // Reading the status register clears what it returned
    always_comb begin
        evt_clr = '0;
        if (s_axi_arvalid && s.ar_rdy && s_axi_araddr == OFF_IRQ_STATUS) begin
            evt_clr = '1;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.sclk_q = ser_clk;
        next_s.latch_q = ser_latch;

        // Status word capture; reserved ranges are never written
        if (results_valid) begin
            next_s.word[POS_B_OPEN2 +: GRP_BITS] = group_b_open_check_second;
            next_s.word[POS_R_OPEN2 +: GRP_BITS] = group_r_open_check_second;
            next_s.word[POS_B_OPEN1 +: GRP_BITS] = group_b_open_check_first;
            next_s.word[POS_R_OPEN1 +: GRP_BITS] = group_r_open_check_first;
            next_s.word[POS_B_NSHORT +: GRP_BITS] = group_b_neighbour_short;
            next_s.word[POS_NU_NSHORT +: GRP_BITS] = unused_pin_neighbour_short;
            next_s.word[POS_R_NSHORT +: GRP_BITS] = group_r_neighbour_short;
            next_s.word[POS_TEF] = thermal_error_flag;
            next_s.word[POS_PTW] = thermal_warning_flag;
            next_s.word[POS_ISF] = ref_resistor_short_fault;
            next_s.word[POS_IOF] = ref_resistor_open_fault;
            next_s.word[POS_B_SHORT2 +: GRP_BITS] = group_b_short_check_second;
            next_s.word[POS_R_SHORT2 +: GRP_BITS] = group_r_short_check_second;
            next_s.word[POS_B_SHORT1 +: GRP_BITS] = group_b_short_check_first;
            next_s.word[POS_R_SHORT1 +: GRP_BITS] = group_r_short_check_first;
        end

        // Self-test codes stay zero until a test has run
        if (neighbour_selftest_done) begin
            next_s.word[POS_NS_CODE +: 3] = neighbour_selftest_failed
                ? SELFTEST_FAIL : SELFTEST_PASS;
        end
        if (open_short_selftest_done) begin
            next_s.word[POS_OS_CODE +: 3] = open_short_selftest_failed
                ? SELFTEST_FAIL : SELFTEST_PASS;
        end

        // Negate bits follow the held values every cycle
        next_s.word[POS_NEGATE_BIT_ONE] = negate_bit_one;
        next_s.word[POS_NEGATE_BIT_ZERO] = negate_bit_zero;

        // Write channels are taken independently, in either order
        if (s_axi_awvalid && s.aw_rdy) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.w_rdy) begin
            next_s.w_got = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end

        // Trade-off: both write channels stall until the response is taken
        // Write executes once both halves are held
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            if (s.aw_addr == OFF_IRQ_MASK) begin
                if (s.w_strb[0]) begin
                    next_s.mask = s.w_data[EVT_W-1:0];
                end
                next_s.bresp = RESP_OKAY;
            end else if (s.aw_addr < OFF_IRQ_MASK) begin
                // Status word and interrupt status are read-only
                next_s.bresp = RESP_SLVERR;
            end else begin
                next_s.bresp = RESP_DECERR;
            end
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Limitation: unaligned offsets below the status register still hit a word
        // Read: one outstanding, answered the cycle after the address
        if (s_axi_arvalid && s.ar_rdy) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = '0;
            next_s.rresp = RESP_OKAY;
            if (s_axi_araddr < OFF_IRQ_STATUS) begin
                for (int i = 0; i < DIAG_WORDS; i++) begin
                    if (s_axi_araddr[ADDR_W-1:2] == i[ADDR_W-3:0]) begin
                        next_s.rdata = s.word[i*32 +: 32];
                    end
                end
            end else if (s_axi_araddr == OFF_IRQ_STATUS) begin
                next_s.rdata = {{(32-EVT_W){1'b0}}, status_q};
            end else if (s_axi_araddr == OFF_IRQ_MASK) begin
                next_s.rdata = {{(32-EVT_W){1'b0}}, s.mask};
            end else begin
                next_s.rresp = RESP_DECERR;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // Ready flags registered so every bus output is a flop
        next_s.aw_rdy = !next_s.aw_got && !next_s.bvalid;
        next_s.w_rdy = !next_s.w_got && !next_s.bvalid;
        next_s.ar_rdy = !next_s.rvalid;

        // Interrupt lags the sticky status by one cycle
        next_s.irq = |(status_q & s.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.word <= WORD_RESET;
            s.mask <= MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ser_out = fr.sdo;
    assign s_axi_awready = s.aw_rdy;
    assign s_axi_wready = s.w_rdy;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.ar_rdy;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign irq = s.irq;
endmodule

// ---- verilog/lds_frame_if.sv ----
`timescale 1ns/1ps
interface lds_frame_if;
    import lds_pkg::*;
    logic load;
    logic shift;
    logic sdi;
    logic [FRAME_BITS-1:0] word;
    logic sdo;
    modport ctl (output load, output shift, output sdi, output word, input sdo);
    modport shf (input load, input shift, input sdi, input word, output sdo);
endinterface

// ---- verilog/lds_pkg.sv ----
package lds_pkg;
    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 288;
    localparam int GRP_BITS = 8;
    localparam int POS_B_OPEN2 = 280;
    localparam int POS_R_OPEN2 = 264;
    localparam int POS_B_OPEN1 = 256;
    localparam int POS_R_OPEN1 = 240;
    localparam int POS_B_NSHORT = 232;
    localparam int POS_NU_NSHORT = 224;
    localparam int POS_R_NSHORT = 216;
    localparam int POS_TEF = 215;
    localparam int POS_PTW = 214;
    localparam int POS_NS_CODE = 211;
    localparam int POS_ISF = 210;
    localparam int POS_IOF = 209;
    localparam int POS_OS_CODE = 206;
    localparam int POS_NEGATE_BIT_ONE = 205;
    localparam int POS_NEGATE_BIT_ZERO = 204;
    localparam int POS_B_SHORT2 = 184;
    localparam int POS_R_SHORT2 = 168;
    localparam int POS_B_SHORT1 = 160;
    localparam int POS_R_SHORT1 = 144;
    localparam logic [2:0] SELFTEST_PASS = 3'h3;
    localparam logic [2:0] SELFTEST_FAIL = 3'h6;
    localparam logic [FRAME_BITS-1:0] WORD_RESET = '0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DIAG_WORDS = 9;
    localparam logic [7:0] OFF_DIAG0 = 8'h00;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // Interrupt event bits
    // ------------------------------------------------------------
    localparam int EVT_W = 8;
    localparam int EVT_OPEN = 0;
    localparam int EVT_SHORT = 1;
    localparam int EVT_NSHORT = 2;
    localparam int EVT_TEF = 3;
    localparam int EVT_PTW = 4;
    localparam int EVT_REF = 5;
    localparam int EVT_SELFTEST = 6;
    localparam int EVT_LATCH = 7;
endpackage

// ---- verilog/lds_shifter.sv ----
`timescale 1ns/1ps
module lds_shifter import lds_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Frame port
    lds_frame_if.shf fr
);
    typedef struct packed {
        logic [FRAME_BITS-1:0] sr;
        logic sdo;
    } lds_shf_t;

    lds_shf_t s;
    lds_shf_t next_s;

    // Load wins over shift; the far end sees the top bit first
    always_comb begin
        next_s = s;
        if (fr.load) begin
            next_s.sr = fr.word;
        end else if (fr.shift) begin
            next_s.sr = {s.sr[FRAME_BITS-2:0], fr.sdi};
        end
        next_s.sdo = next_s.sr[FRAME_BITS-1];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign fr.sdo = s.sdo;
endmodule

// ---- verilog/lds_sticky.sv ----
`timescale 1ns/1ps
module lds_sticky import lds_pkg::*; #(
    parameter int W = EVT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Event set and clear
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] bits;
    } lds_stk_t;

    lds_stk_t s;
    lds_stk_t next_s;

    // A set in the clearing cycle wins, so no event is lost
    always_comb begin
        next_s = s;
        next_s.bits = (s.bits & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.bits;
endmodule
